// file: hdl/csp_clk_pwr_ctrl.sv
// Clock source selection, switching and Sleep/Idle control with APB registers
// Behaviour
// RULE_01: Decode 3-bit source code into oscillator selection
// RULE_02: Primary kind code applies to primary only
// RULE_03: Reset comes up on internal RC divider
// RULE_04: Second oscillator pin function set separately
// RULE_05: Unlocked software may switch to new source
// RULE_06: Sleep stops clocks and halts execution
// RULE_07: Idle halts CPU, peripherals keep clocks
// RULE_08: Interrupt, watchdog time-out or reset wakes
// RULE_09: Sleep shuts down system clock oscillators
// RULE_10: Clock-failure monitor off during Sleep
// RULE_11: Low-power RC runs in Sleep with watchdog
// RULE_12: Watchdog cleared just before entering Sleep
// RULE_13: System-clocked peripherals disabled during Sleep
// RULE_14: Wake resumes on the source used before
// RULE_15: Operand constant picks exactly one request
//
// Local design decisions: the APB interface to the registers and the register addresses.
module csp_clk_pwr_ctrl (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [csp_pkg::APB_AW-1:0]     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           psave_exec,
  input  wire logic [csp_pkg::PSAVE_OP_W-1:0] psave_operand,
  input  wire logic                           irq_wake,
  input  wire logic                           wdt_enabled,
  input  wire logic                           wdt_timeout,
  output logic      [2:0]                     cur_src,
  output logic      [1:0]                     prim_kind,
  output logic                                osc2_io,
  output logic                                int_rc_en,
  output logic                                prim_osc_en,
  output logic                                sec_osc_en,
  output logic                                low_power_rc_osc_en,
  output logic                                pll_en,
  output logic                                rc_div16,
  output logic                                rc_divn,
  output logic                                sys_clk_run,
  output logic                                cpu_run,
  output logic                                periph_clk_en,
  output logic                                fscm_en,
  output logic                                wdt_clear
);
  import csp_pkg::*;

  // All controller state, outputs included
  typedef struct packed {
    csp_pmode_t            mode;
    csp_src_t              cur_src;
    csp_src_t              next_src;
    csp_src_t              saved_src;
    logic                  lock;
    logic                  sw_busy;
    logic [SW_CNT_W-1:0]   sw_cnt;
    logic [1:0]            kind;
    logic                  osc2_io;
    logic                  sleep_seen;
    logic                  idle_seen;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic [1:0]            prim_kind;
    logic                  int_rc_en;
    logic                  prim_osc_en;
    logic                  sec_osc_en;
    logic                  low_power_rc_osc_en;
    logic                  pll_en;
    logic                  rc_div16;
    logic                  rc_divn;
    logic                  sys_clk_run;
    logic                  cpu_run;
    logic                  periph_clk_en;
    logic                  fscm_en;
    logic                  wdt_clear;
  } csp_main_st_t;

  csp_main_st_t st;          // Registered state
  csp_main_st_t nx;          // Next state
  logic         sleep_req;   // From operand decoder
  logic         idle_req;    // From operand decoder
  logic         wr;          // Completing APB write
  logic         setup;       // APB setup phase
  logic         wake;        // Any wake event
  logic         sleeping;    // Next mode is Sleep
  csp_rsel_t    rsel;        // Addressed register

  csp_src_if src_if ();      // Link to source decoder

  // Address to register select, used by read and write paths
  function automatic csp_rsel_t reg_sel(input logic [APB_AW-1:0] a);
    csp_rsel_t r;
    unique case (a)
      OFS_CTRL: r = RSEL_CTRL;
      OFS_CFG:  r = RSEL_CFG;
      OFS_STAT: r = RSEL_STAT;
      default:  r = RSEL_NONE;
    endcase
    return r;
  endfunction : reg_sel

  // Source and kind enables come back registered
  csp_src_decode u_src_decode (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (src_if.dec)
  );

  // Instruction operand decoder
  csp_psave_decode u_psave_decode (
    .pclk      (pclk),
    .presetn   (presetn),
    .exec      (psave_exec),
    .operand   (psave_operand),
    .sleep_req (sleep_req),
    .idle_req  (idle_req)
  );

  assign src_if.sel  = st.cur_src;
  assign src_if.kind = st.kind;

  // Next-state logic
  always_comb
  begin
    nx       = st;
    setup    = psel && !penable;
    wr       = psel && penable && st.pready && pwrite;
    rsel     = reg_sel(paddr);
    wake     = irq_wake || wdt_timeout;                        // [RULE_08]
    sleeping = 1'b0;

    // One wait-free answer: ready raised for the access phase
    nx.pready  = setup;
    nx.pslverr = setup && (rsel == RSEL_NONE);
    if (setup)
    begin
      nx.prdata = '0;
      unique case (rsel)
        RSEL_CTRL:
        begin
          nx.prdata[CTRL_CUR_LSB +: 3]  = st.cur_src;
          nx.prdata[CTRL_NEXT_LSB +: 3] = st.next_src;
          nx.prdata[CTRL_LOCK_BIT]      = st.lock;
          nx.prdata[CTRL_SWREQ_BIT]     = st.sw_busy;
        end
        RSEL_CFG:
        begin
          nx.prdata[CFG_INIT_LSB +: 3] = RST_OSC_SEL;          // [RULE_03]
          nx.prdata[CFG_KIND_LSB +: 2] = st.kind;
          nx.prdata[CFG_OSC2_BIT]      = st.osc2_io;
        end
        RSEL_STAT:
        begin
          nx.prdata[STAT_SLEEP_BIT]     = st.sleep_seen;
          nx.prdata[STAT_IDLE_BIT]      = st.idle_seen;
          nx.prdata[STAT_FSCM_BIT]      = st.fscm_en;
          nx.prdata[STAT_MODE_LSB +: 2] = st.mode;
        end
        RSEL_NONE: nx.prdata = '0;
      endcase
    end

    // Pending switch counts only while a clock runs
    if (st.sw_busy && (st.mode != PM_SLEEP))
    begin
      if (st.sw_cnt == SW_CNT_W'(SWITCH_WAIT_CYC - 1))
      begin
        nx.cur_src = st.next_src;                              // [RULE_05]
        nx.sw_busy = 1'b0;
      end
      else
      begin
        nx.sw_cnt = st.sw_cnt + 1'b1;
      end
    end

    // Control write, ignored once locked
    if (wr && (rsel == RSEL_CTRL) && !st.lock)
    begin
      nx.next_src = csp_src_t'(pwdata[CTRL_NEXT_LSB +: 3]);    // [RULE_05]
      if (pwdata[CTRL_SWREQ_BIT])
      begin
        nx.sw_busy = 1'b1;                                     // [RULE_05]
        nx.sw_cnt  = '0;
      end
      nx.lock = pwdata[CTRL_LOCK_BIT];
    end

    // Configuration write, also blocked by the lock
    if (wr && (rsel == RSEL_CFG) && !st.lock)
    begin
      nx.kind    = pwdata[CFG_KIND_LSB +: 2];                  // [RULE_02]
      nx.osc2_io = pwdata[CFG_OSC2_BIT];                       // [RULE_04]
    end

    // Sticky clear first, so a same-cycle set below wins
    if (wr && (rsel == RSEL_STAT))
    begin
      nx.sleep_seen = st.sleep_seen && !pwdata[STAT_SLEEP_BIT];
      nx.idle_seen  = st.idle_seen && !pwdata[STAT_IDLE_BIT];
    end

    // Power mode sequencing
    nx.wdt_clear = 1'b0;
    unique case (st.mode)
      PM_RUN:
      begin
        if (sleep_req)
        begin
          nx.mode       = PM_SLEEP;                            // [RULE_06]
          nx.saved_src  = nx.cur_src;                          // [RULE_14]
          nx.sleep_seen = 1'b1;
          nx.wdt_clear  = wdt_enabled;                         // [RULE_12]
        end
        else if (idle_req)
        begin
          nx.mode      = PM_IDLE;                              // [RULE_07]
          nx.idle_seen = 1'b1;
        end
      end
      PM_IDLE:
      begin
        if (wake)
        begin
          nx.mode = PM_RUN;                                    // [RULE_08]
        end
      end
      PM_SLEEP:
      begin
        if (wake)
        begin
          nx.mode    = PM_RUN;                                 // [RULE_08]
          nx.cur_src = st.saved_src;                           // [RULE_14]
        end
      end
      default: nx.mode = PM_RUN;
    endcase

    // Output gating follows the next mode so flags and pins agree
    sleeping         = (nx.mode == PM_SLEEP);
    nx.sys_clk_run   = !sleeping;                              // [RULE_06]
    nx.cpu_run       = (nx.mode == PM_RUN);                    // [RULE_07]
    nx.periph_clk_en = !sleeping;                              // [RULE_13]
    nx.fscm_en       = !sleeping;                              // [RULE_10]
    nx.int_rc_en     = src_if.int_rc_on && !sleeping;          // [RULE_09]
    nx.prim_osc_en   = src_if.prim_on && !sleeping;            // [RULE_09]
    nx.sec_osc_en    = src_if.sec_on && !sleeping;             // [RULE_09]
    nx.pll_en        = src_if.pll_on && !sleeping;             // [RULE_09]
    nx.low_power_rc_osc_en       = (src_if.low_power_rc_osc_on && !sleeping) || wdt_enabled;  // [RULE_11]
    nx.rc_div16      = src_if.div16;                           // [RULE_01]
    nx.rc_divn       = src_if.divn;                            // [RULE_01]
    nx.prim_kind     = src_if.kind_eff;                        // [RULE_02]
  end

  // State register; reset selects the default internal RC source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st               <= '0;
      st.mode          <= PM_RUN;
      st.cur_src       <= RST_OSC_SEL;                         // [RULE_03]
      st.next_src      <= RST_OSC_SEL;
      st.saved_src     <= RST_OSC_SEL;
      st.kind          <= RST_KIND_CFG;
      st.osc2_io       <= RST_OSC2_CFG;
      st.prim_kind     <= KIND_OFF;
      st.int_rc_en     <= 1'b1;
      st.rc_divn       <= 1'b1;
      st.sys_clk_run   <= 1'b1;
      st.cpu_run       <= 1'b1;
      st.periph_clk_en <= 1'b1;
      st.fscm_en       <= 1'b1;
    end
    else
    begin
      st <= nx;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign cur_src       = st.cur_src;
  assign prim_kind     = st.prim_kind;
  assign osc2_io       = st.osc2_io;
  assign int_rc_en     = st.int_rc_en;
  assign prim_osc_en   = st.prim_osc_en;
  assign sec_osc_en    = st.sec_osc_en;
  assign low_power_rc_osc_en       = st.low_power_rc_osc_en;
  assign pll_en        = st.pll_en;
  assign rc_div16      = st.rc_div16;
  assign rc_divn       = st.rc_divn;
  assign sys_clk_run   = st.sys_clk_run;
  assign cpu_run       = st.cpu_run;
  assign periph_clk_en = st.periph_clk_en;
  assign fscm_en       = st.fscm_en;
  assign wdt_clear     = st.wdt_clear;

  // Checks beside the logic
  property p_sleep_stop;
    @(posedge pclk) disable iff (!presetn)
    (sleep_req && st.mode == PM_RUN) |=> (!sys_clk_run && !cpu_run && !periph_clk_en);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("sleep did not stop clocks"); // [RULE_06]

  property p_idle_cpu;
    @(posedge pclk) disable iff (!presetn)
    (idle_req && !sleep_req && st.mode == PM_RUN) |=> (!cpu_run && periph_clk_en);
  endproperty
  a_idle_cpu: assert property (p_idle_cpu) else $error("idle gating wrong"); // [RULE_07]

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    (st.mode != PM_RUN && (irq_wake || wdt_timeout)) |=> (cpu_run && sys_clk_run);
  endproperty
  a_wake: assert property (p_wake) else $error("wake event ignored"); // [RULE_08]

  property p_osc_off;
    @(posedge pclk) disable iff (!presetn)
    !sys_clk_run |-> !(int_rc_en || prim_osc_en || sec_osc_en || pll_en);
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator on in sleep"); // [RULE_09]

  property p_fscm;
    @(posedge pclk) disable iff (!presetn)
    $fell(sys_clk_run) |-> (!fscm_en && $past(fscm_en));
  endproperty
  a_fscm: assert property (p_fscm) else $error("monitor active in sleep"); // [RULE_10]

  property p_low_power_rc_osc;
    @(posedge pclk) disable iff (!presetn)
    (!sys_clk_run && $past(wdt_enabled)) |-> low_power_rc_osc_en;
  endproperty
  a_low_power_rc_osc: assert property (p_low_power_rc_osc) else $error("low-power rc stopped"); // [RULE_11]

  property p_wdt_clr;
    @(posedge pclk) disable iff (!presetn)
    (sleep_req && st.mode == PM_RUN && wdt_enabled) |=> (wdt_clear && !sys_clk_run) ##1 !wdt_clear;
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared"); // [RULE_12]

  property p_resume;
    @(posedge pclk) disable iff (!presetn)
    (st.mode == PM_SLEEP && wake) |=> (cur_src == $past(st.saved_src));
  endproperty
  a_resume: assert property (p_resume) else $error("wrong source on wake"); // [RULE_14]

  property p_switch;
    @(posedge pclk) disable iff (!presetn)
    (wr && rsel == RSEL_CTRL && !st.lock && pwdata[CTRL_SWREQ_BIT] && st.mode == PM_RUN
     && !sleep_req && !idle_req) |=> st.sw_busy ##4 (cur_src == st.next_src && !st.sw_busy);
  endproperty
  a_switch: assert property (p_switch) else $error("source switch late"); // [RULE_05]

  c_sleep: cover property (@(posedge pclk) disable iff (!presetn) $fell(sys_clk_run));
  c_idle:  cover property (@(posedge pclk) disable iff (!presetn) $fell(cpu_run) && sys_clk_run);
  c_wake:  cover property (@(posedge pclk) disable iff (!presetn) $rose(sys_clk_run));
  c_swap:  cover property (@(posedge pclk) disable iff (!presetn) $fell(st.sw_busy));

endmodule : csp_clk_pwr_ctrl

// file: include/csp_pkg.sv
// Shared constants, codes and register map of the clock source and power-save controller
package csp_pkg;

  // Register byte offsets on the APB bus
  localparam int          APB_AW   = 8;
  localparam logic [7:0]  OFS_CTRL = 8'h00;  // Oscillator control
  localparam logic [7:0]  OFS_CFG  = 8'h04;  // Oscillator configuration
  localparam logic [7:0]  OFS_STAT = 8'h08;  // Power-save status

  // Control register fields
  localparam int CTRL_SWREQ_BIT = 0;   // Write 1 starts a switch, reads busy
  localparam int CTRL_LOCK_BIT  = 7;   // Set-only lock of clock settings
  localparam int CTRL_NEXT_LSB  = 8;   // next_osc_select field
  localparam int CTRL_CUR_LSB   = 12;  // Current source, read-only

  // Configuration register fields
  localparam int CFG_INIT_LSB = 0;   // initial_osc_select_cfg, read-only
  localparam int CFG_KIND_LSB = 4;   // primary_osc_kind_cfg
  localparam int CFG_OSC2_BIT = 6;   // osc2_pin_function_cfg

  // Status register fields
  localparam int STAT_SLEEP_BIT = 0;  // Sticky, write 1 to clear
  localparam int STAT_IDLE_BIT  = 1;  // Sticky, write 1 to clear
  localparam int STAT_FSCM_BIT  = 2;  // Clock-failure monitor running
  localparam int STAT_MODE_LSB  = 4;  // Present power mode

  // Oscillator source codes
  typedef enum logic [2:0] {
    SRC_INT_FAST_RC  = 3'b000,
    SRC_INT_RC_PLL   = 3'b001,
    SRC_PRIMARY      = 3'b010,
    SRC_PRIMARY_PLL  = 3'b011,
    SRC_SECONDARY    = 3'b100,
    SRC_LOW_POWER_RC = 3'b101,
    SRC_INT_RC_DIV16 = 3'b110,
    SRC_INT_RC_DIVN  = 3'b111
  } csp_src_t;

  // Primary oscillator kinds
  typedef enum logic [1:0] {
    KIND_EXT_CLOCK = 2'b00,
    KIND_STD_XTAL  = 2'b01,
    KIND_HS_XTAL   = 2'b10,
    KIND_OFF       = 2'b11
  } csp_kind_t;

  // Power modes
  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_IDLE  = 2'b01,
    PM_SLEEP = 2'b10
  } csp_pmode_t;

  // Register select codes
  typedef enum logic [1:0] {
    RSEL_CTRL = 2'b00,
    RSEL_CFG  = 2'b01,
    RSEL_STAT = 2'b10,
    RSEL_NONE = 2'b11
  } csp_rsel_t;

  // Values after reset
  localparam csp_src_t  RST_OSC_SEL  = SRC_INT_RC_DIVN;
  localparam csp_kind_t RST_KIND_CFG = KIND_OFF;
  localparam logic      RST_OSC2_CFG = 1'b0;

  // Power-save instruction operands
  localparam int          PSAVE_OP_W = 16;
  localparam logic [15:0] SLEEP_OP   = 16'h0000;
  localparam logic [15:0] IDLE_OP    = 16'h0001;

  // Source switch settle time in cycles
  localparam int SWITCH_WAIT_CYC = 4;
  localparam int SW_CNT_W        = $clog2(SWITCH_WAIT_CYC);

endpackage : csp_pkg

// file: include/csp_src_if.sv
// Carrier between the controller and the source decoder
interface csp_src_if;
  logic [2:0] sel;        // Selected source code
  logic [1:0] kind;       // Primary oscillator kind setting
  logic       int_rc_on;  // Internal fast RC needed
  logic       prim_on;    // Primary oscillator needed
  logic       sec_on;     // Secondary oscillator needed
  logic       low_power_rc_osc_on;    // Low-power RC needed
  logic       pll_on;     // PLL in path
  logic       div16;      // Fixed divide by 16
  logic       divn;       // Programmable divider
  logic [1:0] kind_eff;   // Kind as applied, off when unused

  modport dec (input sel, input kind, output int_rc_on, output prim_on, output sec_on,
               output low_power_rc_osc_on, output pll_on, output div16, output divn, output kind_eff);
  modport ctl (output sel, output kind, input int_rc_on, input prim_on, input sec_on,
               input low_power_rc_osc_on, input pll_on, input div16, input divn, input kind_eff);
endinterface : csp_src_if

// file: hdl/csp_src_decode.sv
// Registered decoder from source code and primary kind to oscillator enables
module csp_src_decode (
  input wire logic pclk,
  input wire logic presetn,
  csp_src_if.dec   s
);
  import csp_pkg::*;

  // All decoder state
  typedef struct packed {
    logic       int_rc_on;
    logic       prim_on;
    logic       sec_on;
    logic       low_power_rc_osc_on;
    logic       pll_on;
    logic       div16;
    logic       divn;
    logic [1:0] kind_eff;
  } csp_dec_st_t;

  csp_dec_st_t st;   // Registered state
  csp_dec_st_t nx;   // Next state

  // Source code to enables
  always_comb
  begin
    nx          = '0;
    nx.kind_eff = KIND_OFF;
    unique case (csp_src_t'(s.sel))                            // [RULE_01]
      SRC_INT_RC_DIVN:  begin nx.int_rc_on = 1'b1; nx.divn  = 1'b1; end
      SRC_INT_RC_DIV16: begin nx.int_rc_on = 1'b1; nx.div16 = 1'b1; end
      SRC_LOW_POWER_RC: nx.low_power_rc_osc_on = 1'b1;
      SRC_SECONDARY:    nx.sec_on  = 1'b1;
      SRC_PRIMARY_PLL:  begin nx.prim_on = 1'b1; nx.pll_on = 1'b1; end
      SRC_PRIMARY:      nx.prim_on = 1'b1;
      SRC_INT_RC_PLL:   begin nx.int_rc_on = 1'b1; nx.pll_on = 1'b1; end
      SRC_INT_FAST_RC:  nx.int_rc_on = 1'b1;
    endcase
    // Kind only matters for a primary source
    if (nx.prim_on)
    begin
      nx.kind_eff = s.kind;                                    // [RULE_02]
    end
  end

  // Reset matches the default internal RC with divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st          <= '0;
      st.int_rc_on <= 1'b1;
      st.divn     <= 1'b1;
      st.kind_eff <= KIND_OFF;
    end
    else
    begin
      st <= nx;
    end
  end

  assign s.int_rc_on = st.int_rc_on;
  assign s.prim_on   = st.prim_on;
  assign s.sec_on    = st.sec_on;
  assign s.low_power_rc_osc_on   = st.low_power_rc_osc_on;
  assign s.pll_on    = st.pll_on;
  assign s.div16     = st.div16;
  assign s.divn      = st.divn;
  assign s.kind_eff  = st.kind_eff;

endmodule : csp_src_decode

// file: hdl/csp_psave_decode.sv
// Decoder of the power-save instruction operand into sleep or idle requests
module csp_psave_decode (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           exec,
  input  wire logic [csp_pkg::PSAVE_OP_W-1:0] operand,
  output logic                                sleep_req,
  output logic                                idle_req
);
  import csp_pkg::*;

  // Request pulses
  typedef struct packed {
    logic sleep_req;
    logic idle_req;
  } csp_psd_st_t;

  csp_psd_st_t st;   // Registered requests
  csp_psd_st_t nx;   // Next requests

  // Operands other than the two constants are dropped
  always_comb
  begin
    nx           = '0;
    nx.sleep_req = exec && (operand == SLEEP_OP);   // [RULE_15]
    nx.idle_req  = exec && (operand == IDLE_OP);    // [RULE_15]
  end

  // Pulses last one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  assign sleep_req = st.sleep_req;
  assign idle_req  = st.idle_req;

endmodule : csp_psave_decode

// file: testbench/csp_cpu_model.sv
// Behavioural CPU core that issues the power-save instruction on command
module csp_cpu_model
  import csp_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  cpu_run,
  input  wire logic                  do_exec,
  input  wire logic [PSAVE_OP_W-1:0] op,
  output logic                       psave_exec,
  output logic      [PSAVE_OP_W-1:0] psave_operand
);
  timeunit 1ns;
  timeprecision 1ps;

  // Execute only while clocked; operand is garbage outside the pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      psave_exec    <= 1'b0;
      psave_operand <= 16'hA5A5;
    end
    else
    begin
      psave_exec    <= do_exec & cpu_run;
      psave_operand <= (do_exec & cpu_run) ? op : ~psave_operand;
    end
  end
endmodule : csp_cpu_model

// file: testbench/csp_clk_pwr_ctrl_tb_top.sv
// Self-checking bench of the clock source and power-save controller
module csp_clk_pwr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import csp_pkg::*;

  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, err, psave_exec, irq_wake = 0, wdt_enabled = 0;
  logic        wdt_timeout = 0, do_exec = 0, wclr_seen = 0;
  logic [15:0] psave_operand, op = 0;
  logic [2:0]  cur_src;
  logic [1:0]  prim_kind;
  logic        osc2_io, int_rc_en, prim_osc_en, sec_osc_en, low_power_rc_osc_en, pll_en, rc_div16;
  logic        rc_divn, sys_clk_run, cpu_run, periph_clk_en, fscm_en, wdt_clear;
  int          failures = 0, total_checks = 0;

  // 10 MHz clock
  always #50 pclk = ~pclk;
  // Catch the one-cycle watchdog clear pulse
  always @(posedge pclk) if (wdt_clear === 1'b1) wclr_seen <= 1'b1;

  csp_clk_pwr_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psave_exec(psave_exec), .psave_operand(psave_operand),
    .irq_wake(irq_wake), .wdt_enabled(wdt_enabled), .wdt_timeout(wdt_timeout),
    .cur_src(cur_src), .prim_kind(prim_kind), .osc2_io(osc2_io), .int_rc_en(int_rc_en),
    .prim_osc_en(prim_osc_en), .sec_osc_en(sec_osc_en), .low_power_rc_osc_en(low_power_rc_osc_en), .pll_en(pll_en),
    .rc_div16(rc_div16), .rc_divn(rc_divn), .sys_clk_run(sys_clk_run), .cpu_run(cpu_run),
    .periph_clk_en(periph_clk_en), .fscm_en(fscm_en), .wdt_clear(wdt_clear));

  csp_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .cpu_run(cpu_run), .do_exec(do_exec),
    .op(op), .psave_exec(psave_exec), .psave_operand(psave_operand));

  // Compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer, held until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // No cycle limit here: only the watchdog ends a stuck wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  // Power-save instruction through the core model
  task exec(input logic [15:0] o);
    @(posedge pclk);
    do_exec <= 1; op <= o;
    @(posedge pclk);
    do_exec <= 0;
    repeat (4) @(negedge pclk);
  endtask : exec

  // Reset values and read-only initial source
  task t_reset;
    check({cur_src, prim_kind, int_rc_en, rc_divn, prim_osc_en}, {3'b111, 2'b11, 3'b110});
    apb(0, OFS_CFG, 0);
    check(q[5:0], 6'h37);
    apb(0, 8'h0C, 0);
    check(err, 1'b1);
    check(q, 32'h0000_0000);
  endtask : t_reset

  // Every source code, decoded enables and kind
  task t_switch;
    logic [2:0] c;
    logic       p;
    apb(1, OFS_CFG, 32'h0000_0060);
    // Write lands on the closing edge; look once it has settled
    @(negedge pclk);
    check(osc2_io, 1);
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      p = (c == 3'b010) || (c == 3'b011);
      apb(1, OFS_CTRL, {21'h0, c, 7'h0, 1'b1});
      repeat (10) @(negedge pclk);
      check(cur_src, c);
      check({int_rc_en, prim_osc_en, sec_osc_en, low_power_rc_osc_en, pll_en, rc_div16, rc_divn},
        {c inside {0, 1, 6, 7}, p, c == 4, c == 5, c == 1 || c == 3, c == 6, c == 7});
      check(prim_kind, p ? 2'b10 : 2'b11);
    end
  endtask : t_switch

  // Sleep entry, reduced clocks, wake on interrupt or watchdog
  task t_sleep(input logic wdt_on, input logic by_wdt);
    @(posedge pclk);
    wdt_enabled <= wdt_on; wclr_seen <= 0;
    exec(SLEEP_OP);
    check({sys_clk_run, cpu_run, periph_clk_en, fscm_en}, 0);
    check({int_rc_en, prim_osc_en, low_power_rc_osc_en}, {2'b00, wdt_on});
    check(wclr_seen, wdt_on);
    exec(IDLE_OP);
    check(cpu_run, 0);
    @(posedge pclk);
    if (by_wdt) wdt_timeout <= 1; else irq_wake <= 1;
    @(posedge pclk);
    wdt_timeout <= 0; irq_wake <= 0;
    repeat (3) @(negedge pclk);
    check({sys_clk_run, cpu_run, fscm_en, int_rc_en, cur_src}, 7'h7F);
    apb(0, OFS_STAT, 0);
    check({q[5:4], q[0]}, 3'b001);
    apb(1, OFS_STAT, 32'h0000_0003);
  endtask : t_sleep

  // Idle keeps peripherals clocked; unknown operands do nothing
  task t_idle;
    wdt_enabled <= 0;
    exec(IDLE_OP);
    check({sys_clk_run, cpu_run, periph_clk_en, int_rc_en}, 4'b1011);
    @(posedge pclk);
    irq_wake <= 1;
    @(posedge pclk);
    irq_wake <= 0;
    repeat (2) @(negedge pclk);
    check(cpu_run, 1);
    exec(16'h0002);
    check({sys_clk_run, cpu_run}, 2'b11);
  endtask : t_idle

  // Locked settings refuse a new source
  task t_lock;
    apb(1, OFS_CTRL, 32'h0000_0080);
    apb(1, OFS_CTRL, 32'h0000_0201);
    repeat (10) @(negedge pclk);
    check(cur_src, 3'b111);
    apb(0, OFS_CTRL, 0);
    check(q[14:12], 3'b111);
  endtask : t_lock

  // Device reset in mid-run also wakes from Sleep
  task t_rst_wake;
    exec(SLEEP_OP);
    check(sys_clk_run, 0);
    @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    repeat (2) @(negedge pclk);
    check({sys_clk_run, cpu_run, periph_clk_en, cur_src}, 6'h3F);
  endtask : t_rst_wake

  // Verdict and end of run
  task results;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(negedge pclk);
    t_reset();
    t_switch();
    t_sleep(1, 0);
    t_sleep(0, 1);
    t_idle();
    t_lock();
    t_rst_wake();
    results();
  end

  // Watchdog against a hang
  initial
  begin
    #(100 * 5000);
    failures++;
    results();
  end
endmodule : csp_clk_pwr_ctrl_tb_top
